// file: verif/data_memory_access_unit_bench.sv
/*
  Self-checking bench of the data-memory access unit with an off-chip
  memory model on its move-external bus.
  Assumes the design's package and modules are compiled first.
*/
`timescale 1ns/1ps
module data_memory_access_unit_bench;
  import dmau_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqWide = 1'b0;
  logic [15:0] reqAddr = 16'h0000, reqWdata = 16'h0000;
  logic reqReady, reqDone;
  logic [15:0] rdData, addrPortOut, snapAddr;
  logic sfrWrite = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, p2Latch = 8'h00;
  logic [7:0] sfrRdata, decRamAddr, bitByteAddr, port0Out, port2Out;
  logic [1:0] bank = 2'h0;
  logic [7:0] decAddr = 8'h00, bitAddr = 8'h00, p0Pin, memData, snapP2;
  logic decInd = 1'b0, decUseReg = 1'b0;
  logic [2:0] decCode = 3'h0;
  logic decSfrSel, decSfrBitable, bitInSfr, port0OeN, addrPortOeN;
  logic latchPulse, read_strobe_n, write_strobe_n, p0LatchFill;
  logic memDrive, snapAOe, latchInv = 1'b0, addrless = 1'b0, wrPrev;
  logic [20:0] pinsNow, pinsPrev;
  int miscompares = 0, cmp_count = 0, stbRun = 0, latRun = 0, latCnt = 0;
  int lastStrobe = 0, lastLatch = 0, fillCnt = 0, wrBad = 0, pinMoves = 0;
  // ==========================================================
  // Clock, pins and instances.
  always #12.5 ref_clk = ~ref_clk;
  // Port 0 has pull-ups, so a released bus reads all ones.
  assign p0Pin = !port0OeN ? port0Out : (memDrive ? memData : 8'hff);
  dmau_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqWide(reqWide),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
    .reqDone(reqDone), .rdData(rdData), .sfrWrite(sfrWrite),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .p2Latch(p2Latch), .programStatusWordBank(bank), .decAddr(decAddr),
    .decIndirect(decInd), .decUseReg(decUseReg), .decRegCode(decCode),
    .bitAddr(bitAddr), .decRamAddr(decRamAddr), .decSfrSel(decSfrSel),
    .decSfrBitable(decSfrBitable), .bitByteAddr(bitByteAddr),
    .bitInSfr(bitInSfr), .port0In(p0Pin), .port0Out(port0Out),
    .port0OeN(port0OeN), .port2Out(port2Out), .addrPortOut(addrPortOut),
    .addrPortOeN(addrPortOeN), .latchPulse(latchPulse),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .p0LatchFill(p0LatchFill));
  dmau_ext_sram mem (.latchPulse(latchPulse), .latchInv(latchInv),
    .addrless(addrless), .p0Pin(p0Pin), .port2Out(port2Out),
    .addrPortOut(addrPortOut), .addrPortOeN(addrPortOeN),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .memDrive(memDrive), .memData(memData));
  // ==========================================================
  // Pin monitor: pulse lengths, fills, write data drive, quiet pins.
  always @(posedge ref_clk) begin
    if (!(read_strobe_n & write_strobe_n)) begin
      stbRun++;
      snapP2 = port2Out;
      snapAddr = addrPortOut;
      snapAOe = addrPortOeN;
    end else if (stbRun != 0) begin
      lastStrobe = stbRun;
      stbRun = 0;
    end
    if (latchPulse ^ latchInv) begin
      latRun++;
      latCnt++;
    end else if (latRun != 0) begin
      lastLatch = latRun;
      latRun = 0;
    end
    if (p0LatchFill === 1'b1) fillCnt++;
    // Data must be driven through the strobe and one hold cycle after.
    if ((!write_strobe_n || wrPrev) && port0OeN !== 1'b0) wrBad++;
    wrPrev = !write_strobe_n;
    pinsNow = {latchPulse, read_strobe_n, write_strobe_n, port0OeN,
               port0Out, port2Out, sfrRdata[0]};
    if (pinsNow[20:1] !== pinsPrev[20:1]) pinMoves++;
    pinsPrev = pinsNow;
  end
  // ==========================================================
  // Tasks: compare, verdict, register port and request port.
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask : check
  task automatic results();
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfrWrite = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge ref_clk);
    sfrWrite = 1'b0;
    // An idle cycle keeps a following write from re-raising the strobe
    // in the very step that lowered it.
    @(negedge ref_clk);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr = a;
    @(negedge ref_clk);
    check(sfrRdata, e);
  endtask : sfr_rd
  // The request is held until taken; the count runs from the take edge.
  task automatic xfer(input logic w, input logic wide,
                      input logic [15:0] a, input logic [15:0] d,
                      output int n);
    reqValid = 1'b1;
    reqWrite = w;
    reqWide = wide;
    reqAddr = a;
    reqWdata = d;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    // The first sample after the take edge already lies one cycle on.
    n = 1;
    @(negedge ref_clk);
    reqValid = 1'b0;
    while (reqDone !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    // A request that never completes counts as a mismatch.
    if (reqDone !== 1'b1) miscompares++;
  endtask : xfer
  task automatic dec(input logic ind, input logic useReg, input logic [1:0] b,
                     input logic [2:0] c, input logic [7:0] a,
                     input logic [7:0] ba);
    {decInd, decUseReg, bank, decCode, decAddr, bitAddr} = {ind, useReg, b,
                                                           c, a, ba};
    @(negedge ref_clk);
  endtask : dec
  // ==========================================================
  // Watchdog, sized well above the longest expected run.
  initial begin
    #500us;
    miscompares++;
    results();
  end
  // ==========================================================
  // Main sequence.
  initial begin : main
    logic [7:0] tab [6] = '{8'h10, 8'h7f, 8'h9a, 8'hc5, 8'h23, 8'h01};
    logic [7:0] aux [6] = '{8'h00, 8'h80, 8'h40, 8'h00, 8'h00, 8'h00};
    logic [15:0] a, d;
    logic [3:0] k;
    int n, ll, ss, ww, bb, ex, f0, l0, m0;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    check(read_strobe_n, 1'b1);
    check(write_strobe_n, 1'b1);
    check(port0OeN, 1'b1);
    sfr_rd(SFR_TIMING, 8'h00);
    sfr_rd(SFR_MEM_AUX, 8'h00);
    sfr_rd(SFR_BUS_AUX, 8'h00);
    sfr_rd(SFR_ROUTE_AUX, 8'h00);
    sfr_rd(8'h90, 8'h00);
    sfr_wr(SFR_BUS_AUX, 8'hff);
    sfr_rd(SFR_BUS_AUX, 8'hcf);
    sfr_wr(SFR_ROUTE_AUX, 8'h5a);
    sfr_rd(SFR_ROUTE_AUX, 8'h5a);
    sfr_wr(SFR_TIMING, 8'ha5);
    sfr_rd(SFR_TIMING, 8'ha5);
    sfr_wr(SFR_BUS_AUX, 8'h00);
    $display("registers test done");
    dec(1'b0, 1'b0, 2'h0, 3'h0, 8'h88, 8'h2b);
    check(decSfrSel, 1'b1);
    check(decSfrBitable, 1'b1);
    check({bitInSfr, bitByteAddr}, 16'h0025);
    dec(1'b1, 1'b0, 2'h0, 3'h0, 8'h85, 8'he3);
    check({decSfrSel, decRamAddr}, 16'h0085);
    check({bitInSfr, bitByteAddr}, 16'h01e0);
    dec(1'b0, 1'b0, 2'h0, 3'h0, 8'h85, 8'h00);
    check({decSfrSel, decSfrBitable}, 16'h0002);
    dec(1'b0, 1'b1, 2'h2, 3'h5, 8'h00, 8'h00);
    check({decSfrSel, decRamAddr}, 16'h0015);
    $display("decode test done");
    m0 = pinMoves;
    f0 = fillCnt;
    xfer(1'b1, 1'b1, EXP_RAM_LAST, 16'h003c, n);
    check(16'(n), 16'h0001);
    xfer(1'b0, 1'b0, EXP_RAM_LAST, 16'h0000, n);
    check(16'(n), 16'h0002);
    check(rdData, 16'h003c);
    xfer(1'b0, 1'b1, 16'h0f00, 16'h0000, n);
    check(rdData, 16'h00ff);
    check(16'(pinMoves - m0 + fillCnt - f0), 16'h0000);
    $display("expanded RAM test done");
    sfr_wr(SFR_MEM_AUX, 8'h02);
    for (int i = 0; i < 6; i++) begin
      k = 4'(i);
      a = {4'h1, k, 4'h6, k};
      d = {4'ha, k, 4'h3, k};
      p2Latch = 8'h20 + 8'(i);
      sfr_wr(SFR_TIMING, tab[i]);
      sfr_wr(SFR_BUS_AUX, aux[i]);
      latchInv = aux[i][7];
      addrless = tab[i][7];
      ll = tab[i][5:4] + 1;
      ss = tab[i][3] + 1;
      ww = tab[i][2:0] + 1;
      bb = tab[i][6] + 1;
      ex = 1 + (addrless ? 0 : 2 * ll) + bb * (2 * ss + ww);
      f0 = fillCnt;
      l0 = latCnt;
      wrBad = 0;
      xfer(1'b1, k[0], a, d, n);
      check(16'(n), 16'(ex));
      check(16'(lastStrobe), 16'(ww));
      check(16'(fillCnt - f0), 16'h0001);
      check(16'(wrBad), 16'h0000);
      if (!addrless) begin
        check(16'(lastLatch), 16'(ll));
        check(snapP2, k[0] ? a[15:8] : p2Latch);
      end else begin
        check(16'(latCnt - l0), 16'h0000);
        check(snapAOe, !aux[i][6]);
        if (aux[i][6]) check(snapAddr, {p2Latch, a[7:0]});
      end
      xfer(1'b0, k[0], a, 16'h0000, n);
      check(n >= ex + 1 && n <= ex + 3, 1'b1);
      if (bb == 2) check(rdData, {d[15:8], d[15:8]});
      else check(rdData[7:0], d[7:0]);
      check(port0OeN, 1'b1);
      $display("off-chip timing entry %0d done", i);
    end
    results();
  end : main
endmodule : data_memory_access_unit_bench

// file: verif/dmau_ext_sram.sv
/*
  Behavioural off-chip memory with its address latch, as it stands beside
  the access unit's move-external bus.
  Assumes the bench resolves the Port 0 pins from both drivers, with
  pull-ups, and tells the model the latch polarity and address-less mode.
*/
`timescale 1ns/1ps
module dmau_ext_sram (
  input wire logic latchPulse,
  input wire logic latchInv,
  input wire logic addrless,
  input wire logic [7:0] p0Pin,
  input wire logic [7:0] port2Out,
  input wire logic [15:0] addrPortOut,
  input wire logic addrPortOeN,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  output logic memDrive,
  output logic [7:0] memData
);
  logic [7:0] mem [0:4095];
  logic [7:0] addrLow;
  logic [11:0] idx;
  // ==========================================================
  // Address latch.
  // Transparent while the pulse is active; it holds at the pulse's end.
  always_latch begin
    if (latchPulse ^ latchInv) begin
      addrLow <= p0Pin;
    end
  end
  // An address-less part sees every access at one place unless the address port is enabled.
  assign idx = addrless ? (addrPortOeN ? 12'h000 : addrPortOut[11:0]) :
               {port2Out[3:0], addrLow};
  // ==========================================================
  // Storage.
  // Writes land at the strobe's rising edge, so data must outlast it.
  always @(posedge write_strobe_n) begin
    mem[idx] <= p0Pin;
  end
  // Read data is driven only while the read strobe is low.
  assign memDrive = !read_strobe_n;
  assign memData = mem[idx];
endmodule : dmau_ext_sram

// file: verilog/dmau_onchip_expanded_ram.sv
/*
  On-chip expanded RAM, single port, registered read data.
  Assumes the controller keeps addresses below DEPTH.
*/
`timescale 1ns/1ps
module dmau_exp_ram #(
  parameter int DEPTH = dmau_pkg::EXP_RAM_BYTES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  dmau_exp_ram_if.mem bus
);
  import dmau_pkg::*;
  logic [7:0] store [DEPTH];

  // ==========================================================
  // Storage; the array has no reset, only the read register.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus.rdata <= 8'h00;
    end else if (ce && bus.en) begin
      if (bus.we) begin
        store[bus.addr] <= bus.wdata;
      end
      bus.rdata <= store[bus.addr];
    end
  end
endmodule : dmau_exp_ram

// file: verilog/dmau_onchip_expanded_ram_if.sv
/*
  Carrier between the access unit and its on-chip expanded RAM.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface dmau_exp_ram_if;
  logic en;
  logic we;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata,
                input rdata);
  modport mem (input en, input we, input addr, input wdata,
               output rdata);
endinterface : dmau_exp_ram_if

// file: verilog/dmau_pkg.sv
/*
  Shared constants and types of the data-memory access unit: register
  addresses, field positions, reset values, modes and phases.
  Assumes a single system clock and byte-wide special registers.
*/
package dmau_pkg;
  // ==========================================================
  // Register addresses and reset values.
  localparam logic [7:0] SFR_TIMING = 8'h8f;
  localparam logic [7:0] SFR_MEM_AUX = 8'ha2;
  localparam logic [7:0] SFR_BUS_AUX = 8'ha3;
  localparam logic [7:0] SFR_ROUTE_AUX = 8'ha4;
  localparam logic [7:0] RST_REG = 8'h00;
  // ==========================================================
  // Field positions.
  localparam int OFFCHIP_SEL_BIT = 1;
  localparam int LATCH_INV_BIT = 7;
  localparam int ADDR_OUT_BIT = 6;
  localparam logic [7:0] BUS_AUX_WO_MASK = 8'h30;
  localparam int MODE_ADDRLESS_BIT = 1;
  localparam int MODE_WIDE_BIT = 0;
  // ==========================================================
  // Memory map figures.
  localparam int EXP_RAM_BYTES = 3840;
  localparam logic [15:0] EXP_RAM_LAST = 16'h0eff;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hf8;
  localparam logic [2:0] BITABLE_LOW = 3'h0;
  localparam logic [2:0] BANK_TOP = 3'h0;
  localparam logic [7:0] P0_FILL = 8'hff;
  localparam logic [7:0] RD_MISS = 8'hff;
  // ==========================================================
  // Types.
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] latchWidth;
    logic setupHold;
    logic [2:0] strobeWidth;
  } dmau_timing_type;
  typedef enum logic [2:0] {
    PH_IDLE, PH_LATCH_HI, PH_LATCH_LO, PH_SETUP, PH_STROBE, PH_HOLD,
    PH_CAPTURE
  } dmau_phase_type;
endpackage : dmau_pkg

// file: verilog/dmau_top.sv
/*
  Data-memory access unit: internal address decode, special registers
  for the move-external bus, the off-chip bus sequencer and on-chip
  expanded RAM. Assumes the core holds a request until reqReady.
*/
// Function
// - Select bit routes to off-chip or on-chip RAM
// - On-chip RAM 3840 bytes, move-external only
// - On-chip RAM access leaves all bus pins alone
// - Eight-bit address keeps Port 2 latch value
// - Sixteen-bit address drives high byte Port 2
// - Address-less mode skips address phase
// - Port 0 carries address then data
// - Write data surrounds the write strobe
// - Read data sampled before strobe rises
// - Off-chip access fills Port 0 latch ones
// - Active-low read and write strobes
// - Mode field selects mux/address-less, 8/16 data
// - Latch width field sets both phases
// - Setup/hold bit gives one or two clocks
// - Strobe width is field plus one
// - Polarity bit inverts latch pulse
// - Address-less mode may drive address ports
// - Upper addresses split direct/indirect spaces
// - Four banks of eight working registers
// - Sixteen bytes bit-addressable above banks
// - Special registers at x0/x8 bit-addressable
`timescale 1ns/1ps
module dmau_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqWide,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqWdata,
  output logic reqReady,
  output logic reqDone,
  output logic [15:0] rdData,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic [7:0] p2Latch,
  input wire logic [1:0] programStatusWordBank,
  input wire logic [7:0] decAddr,
  input wire logic decIndirect,
  input wire logic decUseReg,
  input wire logic [2:0] decRegCode,
  input wire logic [7:0] bitAddr,
  output logic [7:0] decRamAddr,
  output logic decSfrSel,
  output logic decSfrBitable,
  output logic [7:0] bitByteAddr,
  output logic bitInSfr,
  input wire logic [7:0] port0In,
  output logic [7:0] port0Out,
  output logic port0OeN,
  output logic [7:0] port2Out,
  output logic [15:0] addrPortOut,
  output logic addrPortOeN,
  output logic latchPulse,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic p0LatchFill
);
  import dmau_pkg::*;

  typedef struct packed {
    dmau_phase_type phase;
    logic [2:0] cnt;
    logic isWrite;
    logic hiByte;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    dmau_timing_type timing;
    logic [7:0] memAux;
    logic [7:0] busAux;
    logic [7:0] routeAux;
    logic [7:0] sfrRdata;
    logic [7:0] p0Sync1;
    logic [7:0] p0Sync2;
    logic [1:0] capPipe;
    logic [1:0] capHi;
    logic ramRd;
    logic ramMiss;
    logic done;
    logic [7:0] p0Out;
    logic p0OeN;
    logic [7:0] p2Out;
    logic [15:0] addrOut;
    logic addrOeN;
    logic latchPin;
    logic rdN;
    logic wrN;
    logic [7:0] decRam;
    logic decSfr;
    logic decBitable;
    logic [7:0] bitByte;
    logic bitSfr;
  } dmau_state_type;

  dmau_state_type st;
  dmau_state_type next_st;
  dmau_exp_ram_if xbus ();
  logic offSel;
  logic start;
  logic wideData;

  dmau_exp_ram u_ram (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .bus(xbus)
  );

  // ==========================================================
  // Request handshake and routing.
  assign offSel = st.memAux[OFFCHIP_SEL_BIT];
  assign wideData = st.timing.mode[MODE_WIDE_BIT];
  assign reqReady = (st.phase == PH_IDLE) && !st.ramRd && !st.done;
  assign start = ce && reqValid && reqReady;
  // The Port 0 latch fill is a pulse for the port's own latch.
  assign p0LatchFill = start && offSel;

  // On-chip RAM port; only the move-external request reaches it.
  assign xbus.en = start && !offSel && (reqAddr <= EXP_RAM_LAST);
  assign xbus.we = reqWrite;
  assign xbus.addr = reqAddr[11:0];
  assign xbus.wdata = reqWdata[7:0];

  // ==========================================================
  // Next-state logic: registers, decoder and bus sequencer.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.p0Sync1 = port0In;
    next_st.p0Sync2 = st.p0Sync1;
    next_st.capPipe = {st.capPipe[0], 1'b0};
    next_st.capHi = {st.capHi[0], 1'b0};
    // Read capture lands two clocks late because of the synchroniser.
    if (st.capPipe[1]) begin
      if (st.capHi[1]) begin
        next_st.rdata[15:8] = st.p0Sync2;
      end else begin
        next_st.rdata[7:0] = st.p0Sync2;
      end
    end

    // Register writes; the write-only pair on the bus aux reads zero.
    if (sfrWrite) begin
      unique case (sfrAddr)
        SFR_TIMING: next_st.timing = sfrWdata;
        SFR_MEM_AUX: next_st.memAux = sfrWdata;
        SFR_BUS_AUX: next_st.busAux = sfrWdata;
        SFR_ROUTE_AUX: next_st.routeAux = sfrWdata;
        default: next_st.routeAux = st.routeAux;
      endcase
    end
    unique case (sfrAddr)
      SFR_TIMING: next_st.sfrRdata = st.timing;
      SFR_MEM_AUX: next_st.sfrRdata = st.memAux;
      SFR_BUS_AUX: next_st.sfrRdata = st.busAux & ~BUS_AUX_WO_MASK;
      SFR_ROUTE_AUX: next_st.sfrRdata = st.routeAux;
      default: next_st.sfrRdata = RST_REG;
    endcase

    // Internal data address decode.
    next_st.decSfr = 1'b0;
    if (decUseReg) begin
      next_st.decRam = {BANK_TOP, programStatusWordBank,
                        decRegCode};
    end else begin
      next_st.decRam = decAddr;
      next_st.decSfr = (decAddr >= UPPER_BASE) && !decIndirect;
    end
    next_st.decBitable = next_st.decSfr &&
                         (decAddr[2:0] == BITABLE_LOW);
    if (bitAddr < UPPER_BASE) begin
      next_st.bitByte = BIT_RAM_BASE + {4'h0, bitAddr[6:3]};
      next_st.bitSfr = 1'b0;
    end else begin
      next_st.bitByte = bitAddr & BIT_SFR_MASK;
      next_st.bitSfr = 1'b1;
    end

    // On-chip RAM completes without touching any pin.
    next_st.ramRd = 1'b0;
    if (st.ramRd) begin
      next_st.rdata = {8'h00, st.ramMiss ? RD_MISS : xbus.rdata};
      next_st.done = 1'b1;
    end

    unique case (st.phase)
      PH_IDLE: begin
        if (start && !offSel) begin
          next_st.ramRd = !reqWrite;
          next_st.ramMiss = (reqAddr > EXP_RAM_LAST);
          next_st.done = reqWrite;
        end else if (start) begin
          next_st.isWrite = reqWrite;
          next_st.hiByte = 1'b0;
          next_st.wdata = reqWdata;
          // Eight-bit form keeps the latch byte as the high address.
          next_st.addr = reqWide ? reqAddr :
                         {p2Latch, reqAddr[7:0]};
          if (st.timing.mode[MODE_ADDRLESS_BIT]) begin
            next_st.phase = PH_SETUP;
            next_st.cnt = {2'b00, st.timing.setupHold};
          end else begin
            next_st.phase = PH_LATCH_HI;
            next_st.cnt = {1'b0, st.timing.latchWidth};
          end
        end
      end
      PH_LATCH_HI: begin
        if (st.cnt == 3'h0) begin
          next_st.phase = PH_LATCH_LO;
          next_st.cnt = {1'b0, st.timing.latchWidth};
        end else begin
          next_st.cnt = st.cnt - 3'h1;
        end
      end
      PH_LATCH_LO, PH_HOLD: begin
        if (st.cnt != 3'h0) begin
          next_st.cnt = st.cnt - 3'h1;
        end else if (st.phase == PH_LATCH_LO ||
                     (wideData && !st.hiByte)) begin
          next_st.phase = PH_SETUP;
          next_st.hiByte = (st.phase == PH_HOLD);
          next_st.cnt = {2'b00, st.timing.setupHold};
        end else if (st.isWrite) begin
          next_st.phase = PH_IDLE;
          next_st.done = 1'b1;
        end else begin
          next_st.phase = PH_CAPTURE;
        end
      end
      PH_SETUP: begin
        if (st.cnt == 3'h0) begin
          next_st.phase = PH_STROBE;
          next_st.cnt = st.timing.strobeWidth;
        end else begin
          next_st.cnt = st.cnt - 3'h1;
        end
      end
      PH_STROBE: begin
        if (st.cnt == 3'h0) begin
          next_st.phase = PH_HOLD;
          next_st.cnt = {2'b00, st.timing.setupHold};
          next_st.capPipe[0] = !st.isWrite;
          next_st.capHi[0] = st.hiByte;
        end else begin
          next_st.cnt = st.cnt - 3'h1;
        end
      end
      PH_CAPTURE: begin
        if (st.capPipe == 2'b00) begin
          next_st.phase = PH_IDLE;
          next_st.done = 1'b1;
        end
      end
    endcase

    // Pin images follow the next phase so every pin is a flip-flop.
    next_st.rdN = !(next_st.phase == PH_STROBE && !next_st.isWrite);
    next_st.wrN = !(next_st.phase == PH_STROBE &&
                    next_st.isWrite);
    next_st.latchPin = (next_st.phase == PH_LATCH_HI) ^
                       next_st.busAux[LATCH_INV_BIT];
    if (next_st.phase == PH_IDLE) begin
      next_st.p2Out = p2Latch;
      next_st.p0OeN = (st.phase == PH_IDLE) ? st.p0OeN : 1'b1;
      next_st.addrOeN = (st.phase == PH_IDLE) ? st.addrOeN : 1'b1;
    end else begin
      next_st.p2Out = next_st.addr[15:8];
      next_st.addrOut = next_st.addr;
      next_st.addrOeN = !(next_st.timing.mode[MODE_ADDRLESS_BIT] &&
                          next_st.busAux[ADDR_OUT_BIT]);
      if (next_st.phase == PH_LATCH_HI ||
          next_st.phase == PH_LATCH_LO) begin
        next_st.p0Out = next_st.addr[7:0];
        next_st.p0OeN = 1'b0;
      end else if (next_st.isWrite &&
                   next_st.phase != PH_CAPTURE) begin
        next_st.p0Out = next_st.hiByte ? next_st.wdata[15:8] :
                        next_st.wdata[7:0];
        next_st.p0OeN = 1'b0;
      end else begin
        next_st.p0OeN = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register; the clock enable freezes everything.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= '0;
      st.phase <= PH_IDLE;
      st.p0OeN <= 1'b1;
      st.addrOeN <= 1'b1;
      st.rdN <= 1'b1;
      st.wrN <= 1'b1;
      st.p0Out <= P0_FILL;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign reqDone = st.done;
  assign rdData = st.rdata;
  assign sfrRdata = st.sfrRdata;
  assign decRamAddr = st.decRam;
  assign decSfrSel = st.decSfr;
  assign decSfrBitable = st.decBitable;
  assign bitByteAddr = st.bitByte;
  assign bitInSfr = st.bitSfr;
  assign port0Out = st.p0Out;
  assign port0OeN = st.p0OeN;
  assign port2Out = st.p2Out;
  assign addrPortOut = st.addrOut;
  assign addrPortOeN = st.addrOeN;
  assign latchPulse = st.latchPin;
  assign read_strobe_n = st.rdN;
  assign write_strobe_n = st.wrN;

  // ==========================================================
  // Checks on the sequencer.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_ROUTE_OFF: assert property (start && offSel |=>
    st.phase != PH_IDLE) else $error("off-chip access not started");
  AST_RAM_QUIET: assert property (start && !offSel |=>
    st.phase == PH_IDLE && read_strobe_n && write_strobe_n
    && $stable(port0OeN)) else $error("pins moved on on-chip RAM access");
  AST_ADDRLESS: assert property (start && offSel &&
    st.timing.mode[MODE_ADDRLESS_BIT] |=> st.phase == PH_SETUP)
    else $error("address phase not skipped");
  AST_MUX_ADDR: assert property (st.phase == PH_LATCH_HI |->
    !port0OeN && port0Out == st.addr[7:0])
    else $error("address missing at latch pulse");
  AST_WR_DATA: assert property (!write_strobe_n |->
    !port0OeN && !$past(port0OeN) ##1 !port0OeN)
    else $error("write data not around strobe");
  AST_P2_HOLD: assert property (st.phase != PH_IDLE |->
    port2Out == st.addr[15:8]) else $error("Port 2 not held");
  AST_ONE_STROBE: assert property (1'b1 |->
    read_strobe_n || write_strobe_n) else $error("both strobes low");
  AST_MIN_STROBE: assert property ($fell(read_strobe_n) &&
    st.timing.strobeWidth == 3'h1 |-> !read_strobe_n ##1 !read_strobe_n
    ##1 read_strobe_n) else $error("strobe width wrong");
  AST_FILL_DONE: assert property (p0LatchFill |->
    ##[1:80] reqDone) else $error("off-chip access never ended");
endmodule : dmau_top
